// *** src/eesl_pkg.sv ***
// Shared constants and types for the two-wire serial EEPROM slave
package eesl_pkg;

   // ============================================================
   // Slave address
   localparam logic [3:0]  DEV_TYPE       = 4'hA;       // Fixed device type code 1010
   localparam int unsigned DEV_RW_BIT     = 0;          // Read (1) / write (0) flag position

   // ============================================================
   // Memory organisation
   localparam int unsigned MEM_ADDR_W     = 16;         // 65,536 bytes
   localparam int unsigned MEM_BYTES      = 65536;
   localparam int unsigned PAGE_ADDR_W    = 7;          // 128 bytes a page
   localparam int unsigned PAGE_BYTES     = 128;
   localparam int unsigned PAGE_SEL_LSB   = 7;          // Upper 9 bits pick the page
   localparam logic [7:0]  ERASED_BYTE    = 8'hFF;      // Contents at delivery

   // ============================================================
   // Bit framing
   localparam logic [3:0]  BIT_CNT_RST    = 4'h0;       // Count of SCL rises in a byte
   localparam logic [3:0]  BIT_CNT_ACK    = 4'h8;       // Eight data bits done, ninth clock next
   localparam logic [3:0]  BIT_CNT_LAST   = 4'h7;

   // ============================================================
   // Internal programming cycle
   localparam int unsigned CLK_FREQ_KHZ   = 100000;     // i_clk at 100 MHz
   localparam int unsigned T_WR_MS        = 5;          // Write cycle time in ms
   localparam int unsigned T_WR_CYCLES    = T_WR_MS * CLK_FREQ_KHZ;
   localparam int unsigned WR_CNT_W       = 20;
   localparam logic [19:0] WR_CNT_RST     = 20'h00000;

   // ============================================================
   // Reset values
   localparam logic [15:0] ADDR_RST       = 16'h0000;
   localparam logic [7:0]  BYTE_RST       = 8'h00;
   localparam logic [127:0] VALID_RST     = 128'h0;

   // ============================================================
   // Protocol states
   typedef enum logic [6:0] {
      ST_IDLE    = 7'b0000001,
      ST_DEVADDR = 7'b0000010,
      ST_ADDRH   = 7'b0000100,
      ST_ADDRL   = 7'b0001000,
      ST_WDATA   = 7'b0010000,
      ST_RDATA   = 7'b0100000,
      ST_IGNORE  = 7'b1000000
   } eesl_state_type;

endpackage : eesl_pkg

// *** src/eesl_top.sv ***
// Two-wire serial EEPROM slave: protocol engine, page buffer and memory array
`timescale 1ns/1ps

module eesl_top #(
   parameter int unsigned P_WRITE_CYCLES = eesl_pkg::T_WR_CYCLES
) (
   // System clock and power-on reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // Serial clock as the link clock and as a sampled level
   input  wire logic i_scl_clk,
   input  wire logic i_scl,
   // Serial data, open-drain
   input  wire logic i_sda_in,
   output logic      o_sda_out,
   output logic      o_sda_oe,
   // Straps and protection
   input  wire logic i_chip_select_bit0,
   input  wire logic i_chip_select_bit1,
   input  wire logic i_chip_select_bit2,
   input  wire logic i_write_protect,
   // Status
   output logic      o_busy
);
   import eesl_pkg::*;

   localparam logic [WR_CNT_W-1:0] WR_LAST = WR_CNT_W'(P_WRITE_CYCLES - 1);

   // ============================================================
   // Link domain: receive shifter on the serial clock
   logic [7:0] link_shift;
   logic [7:0] next_link_shift;

   // Sample SDA on every rising SCL edge; framing is counted in i_clk
   always_comb begin
      next_link_shift = {link_shift[6:0], i_sda_in};
   end

   always_ff @(posedge i_scl_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         link_shift <= BYTE_RST;
      end else begin
         link_shift <= next_link_shift;
      end
   end

   // ============================================================
   // Pin synchronisers
   logic scl_s1, scl_s2, scl_q;
   logic sda_s1, sda_s2, sda_q;
   logic wp_s1, wp_s2;
   logic [2:0] cs_s1, cs_s2;
   logic next_scl_q, next_sda_q;

   always_comb begin
      next_scl_q = scl_s2;
      next_sda_q = sda_s2;
   end

   // Two stages before any i_clk logic looks at a pin
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_q  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_q  <= 1'b1;
         wp_s1  <= 1'b0;
         wp_s2  <= 1'b0;
         cs_s1  <= 3'h0;
         cs_s2  <= 3'h0;
      end else begin
         scl_s1 <= i_scl;
         scl_s2 <= scl_s1;
         scl_q  <= next_scl_q;
         sda_s1 <= i_sda_in;
         sda_s2 <= sda_s1;
         sda_q  <= next_sda_q;
         wp_s1  <= i_write_protect;
         wp_s2  <= wp_s1;
         cs_s1  <= {i_chip_select_bit2, i_chip_select_bit1, i_chip_select_bit0};
         cs_s2  <= cs_s1;
      end
   end

   // ============================================================
   // Bus events
   logic start_det, stop_det, scl_rise, scl_fall;

   // SDA moving while SCL stays high is framing, not data
   assign start_det = scl_s2 & scl_q & sda_q & ~sda_s2;
   assign stop_det  = scl_s2 & scl_q & ~sda_q & sda_s2;
   assign scl_rise  = scl_s2 & ~scl_q;
   assign scl_fall  = ~scl_s2 & scl_q;

   // ============================================================
   // Protocol engine
   eesl_state_type   state, next_state;
   logic [3:0]       cnt, next_cnt;
   logic             ack_slot, next_ack_slot;
   logic             sda_oe, next_sda_oe;
   logic [15:0]      addr, next_addr;
   logic [7:0]       tx, next_tx;
   logic             wp_lock, next_wp_lock;
   logic             wr_pending, next_wr_pending;
   logic [127:0]     pvalid, next_pvalid;
   logic             pbuf_we;
   logic             dev_match, byte_fall, ack_end;
   logic [7:0]       rx_byte, rd_byte;
   logic             busy, next_busy;
   logic [WR_CNT_W-1:0] wcnt, next_wcnt;
   logic             busy_end, launch;

   // Memory array and page buffer
   logic [7:0] mem [0:MEM_BYTES-1];
   logic [7:0] pbuf [0:PAGE_BYTES-1];

   // The shifter last moved at the SCL rise; by the synced fall it has settled
   assign rx_byte   = link_shift;
   assign rd_byte   = mem[addr];
   assign dev_match = (rx_byte[7:4] == DEV_TYPE) && (rx_byte[3:1] == cs_s2);
   assign byte_fall = scl_fall && !ack_slot && (cnt == BIT_CNT_ACK);
   assign ack_end   = scl_fall && ack_slot;
   assign busy_end  = busy && (wcnt == WR_LAST);
   assign launch    = stop_det && wr_pending && !busy;

   always_comb begin
      next_state      = state;
      next_cnt        = cnt;
      next_ack_slot   = ack_slot;
      next_sda_oe     = sda_oe;
      next_addr       = addr;
      next_tx         = tx;
      next_wp_lock    = wp_lock;
      next_wr_pending = wr_pending;
      next_pvalid     = pvalid;
      pbuf_we         = 1'b0;
      if (busy_end) begin
         next_pvalid = VALID_RST;
      end
      if (start_det) begin
         // Repeated START also lands here, clearing the bit counter
         next_state    = ST_DEVADDR;
         next_cnt      = BIT_CNT_RST;
         next_ack_slot = 1'b0;
         next_sda_oe   = 1'b0;
      end else if (stop_det) begin
         next_state      = ST_IDLE;
         next_cnt        = BIT_CNT_RST;
         next_ack_slot   = 1'b0;
         next_sda_oe     = 1'b0;
         next_wr_pending = 1'b0;
      end else begin
         if (scl_rise) begin
            next_cnt = (cnt == BIT_CNT_ACK) ? BIT_CNT_RST : cnt + 4'h1;
            // Master refusal in the ninth clock ends a read
            if (ack_slot && state == ST_RDATA && sda_s2) begin
               next_state = ST_IGNORE;
            end
         end
         if (byte_fall) begin
            next_ack_slot = 1'b1;
            next_sda_oe   = 1'b0;
            case (state)
               ST_DEVADDR: begin
                  if (dev_match && !busy) begin
                     next_sda_oe = 1'b1;
                     next_state  = rx_byte[DEV_RW_BIT] ? ST_RDATA : ST_ADDRH;
                  end else begin
                     next_state = ST_IGNORE;
                  end
               end
               ST_ADDRH: begin
                  next_sda_oe     = 1'b1;
                  next_addr[15:8] = rx_byte;
                  next_state      = ST_ADDRL;
               end
               ST_ADDRL: begin
                  next_sda_oe    = 1'b1;
                  next_addr[7:0] = rx_byte;
                  next_state     = ST_WDATA;
               end
               ST_WDATA: begin
                  if (wp_lock) begin
                     next_state = ST_IGNORE;
                  end else begin
                     next_sda_oe     = 1'b1;
                     pbuf_we         = 1'b1;
                     next_pvalid[addr[PAGE_ADDR_W-1:0]] = 1'b1;
                     next_wr_pending = 1'b1;
                     // Page bits never move during a write
                     next_addr[PAGE_ADDR_W-1:0] = addr[PAGE_ADDR_W-1:0] + 7'h01;
                  end
               end
               default: begin
                  next_sda_oe = 1'b0;  // Read: master owns the ninth clock
               end
            endcase
         end else if (ack_end) begin
            next_ack_slot = 1'b0;
            next_sda_oe   = 1'b0;
            if (state == ST_WDATA && !wr_pending) begin
               // Strobe on the last fall before the first data byte
               next_wp_lock = wp_s2;
            end
            if (state == ST_RDATA) begin
               next_tx     = rd_byte;
               next_sda_oe = ~rd_byte[7];
               next_addr   = addr + 16'h0001;
            end
         end else if (scl_fall && state == ST_RDATA && cnt != BIT_CNT_RST) begin
            next_sda_oe = ~tx[BIT_CNT_LAST[2:0] - cnt[2:0]];
         end
      end
   end

   // Protocol state register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state      <= ST_IDLE;
         cnt        <= BIT_CNT_RST;
         ack_slot   <= 1'b0;
         sda_oe     <= 1'b0;
         addr       <= ADDR_RST;
         tx         <= BYTE_RST;
         wp_lock    <= 1'b0;
         wr_pending <= 1'b0;
         pvalid     <= VALID_RST;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         ack_slot   <= next_ack_slot;
         sda_oe     <= next_sda_oe;
         addr       <= next_addr;
         tx         <= next_tx;
         wp_lock    <= next_wp_lock;
         wr_pending <= next_wr_pending;
         pvalid     <= next_pvalid;
      end
   end

   // ============================================================
   // Programming cycle
   always_comb begin
      next_busy = busy;
      next_wcnt = wcnt;
      if (launch) begin
         next_busy = 1'b1;
         next_wcnt = WR_CNT_RST;
      end else if (busy_end) begin
         next_busy = 1'b0;
         next_wcnt = WR_CNT_RST;
      end else if (busy) begin
         next_wcnt = wcnt + WR_CNT_W'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy <= 1'b0;
         wcnt <= WR_CNT_RST;
      end else begin
         busy <= next_busy;
         wcnt <= next_wcnt;
      end
   end

   // ============================================================
   // Storage
   // Erased at delivery; no reset touches the array, as in a real cell
   initial begin
      for (int i = 0; i < MEM_BYTES; i++) begin
         mem[i] = ERASED_BYTE;
      end
   end

   // Page buffer collects bytes; wrap means later bytes overwrite earlier
   always_ff @(posedge i_clk) begin
      if (pbuf_we) begin
         pbuf[addr[PAGE_ADDR_W-1:0]] <= rx_byte;
      end
   end

   // Commit one buffered byte a cycle during the first 128 busy cycles; plain always as the array is preset at time 0
   always @(posedge i_clk) begin
      if (busy && wcnt < WR_CNT_W'(PAGE_BYTES) && pvalid[wcnt[PAGE_ADDR_W-1:0]]) begin
         mem[{addr[MEM_ADDR_W-1:PAGE_SEL_LSB], wcnt[PAGE_ADDR_W-1:0]}] <= pbuf[wcnt[PAGE_ADDR_W-1:0]];
      end
   end

   // ============================================================
   // Outputs
   logic sda_out_q;
   logic next_sda_out_q;

   // Open drain: the data level is always low, only the enable moves
   always_comb begin
      next_sda_out_q = 1'b0;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sda_out_q <= 1'b0;
      end else begin
         sda_out_q <= next_sda_out_q;
      end
   end

   assign o_sda_out = sda_out_q;
   assign o_sda_oe  = sda_oe;
   assign o_busy    = busy;

   // ============================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_idle_quiet;
      state == ST_IDLE |-> !sda_oe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("SDA driven outside a command");

   property p_stop_launch;
      launch |=> busy && wcnt == WR_CNT_RST && !wr_pending;
   endproperty
   a_stop_launch: assert property (p_stop_launch) else $error("STOP after write did not start programming");

   property p_oe_timing;
      $changed(sda_oe) |-> $past(scl_fall) || $past(start_det) || $past(stop_det);
   endproperty
   a_oe_timing: assert property (p_oe_timing) else $error("SDA changed outside an SCL low edge");

   property p_addr_ack;
      state == ST_DEVADDR && byte_fall && dev_match && !busy |=> sda_oe && ack_slot;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("Matching address not acknowledged");

   property p_busy_nack;
      busy && state == ST_DEVADDR && byte_fall |=> !sda_oe ##1 state != ST_RDATA;
   endproperty
   a_busy_nack: assert property (p_busy_nack) else $error("Address acknowledged while programming");

   property p_page_hold;
      state == ST_WDATA && $past(state) == ST_WDATA |-> addr[15:7] == $past(addr[15:7]);
   endproperty
   a_page_hold: assert property (p_page_hold) else $error("Page moved during a write");

   property p_wp_reject;
      wp_lock && state == ST_WDATA && byte_fall |=> !sda_oe && state == ST_IGNORE && !pvalid[addr[6:0]];
   endproperty
   a_wp_reject: assert property (p_wp_reject) else $error("Protected data byte was accepted");

   property p_read_advance;
      state == ST_RDATA && ack_end |=> addr == $past(addr) + 16'h0001 && tx == $past(rd_byte);
   endproperty
   a_read_advance: assert property (p_read_advance) else $error("Read counter did not advance");

   property p_busy_len;
      $fell(busy) |-> $past(wcnt) == WR_LAST;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("Programming interval has wrong length");

   c_write: cover property (launch ##1 busy);
   c_read_byte: cover property (state == ST_RDATA && ack_end);
   c_busy_poll: cover property (busy && state == ST_DEVADDR && byte_fall);
   c_wp_refuse: cover property (wp_lock && state == ST_WDATA && byte_fall);

endmodule : eesl_top

// *** dv/eesl_bus_master.sv ***
// Two-wire bus master model that owns the serial clock and frames every transfer
`timescale 1ns/1ps
module eesl_bus_master (
   // Bench clock, paces the bit phases only
   input  wire logic i_clk,
   // Resolved data wire
   input  wire logic i_sda,
   // Serial clock and data pull-down
   output logic      o_scl,
   output logic      o_sda_oe
);
   // ============================================================
   // Idle bus
   // Clock parked high and data released between frames
   initial begin
      o_scl    = 1'b1;
      o_sda_oe = 1'b0;
   end

   // ============================================================
   // Bit phases
   // Quarter slot of 80 ns; keeps both clock phases well above the slave's sync needs
   task automatic qtr();
      repeat (8) @(negedge i_clk);
   endtask : qtr

   // Start from idle or as a repeated start from clock low
   task automatic start();
      o_sda_oe = 1'b0;
      qtr();
      o_scl = 1'b1;
      qtr();
      o_sda_oe = 1'b1;
      qtr();
      o_scl = 1'b0;
      qtr();
   endtask : start

   // Stop leaves the clock high, so the bus is idle again
   task automatic stop();
      o_sda_oe = 1'b1;
      qtr();
      o_scl = 1'b1;
      qtr();
      o_sda_oe = 1'b0;
      qtr();
   endtask : stop

   // Data moves only while the clock is low, sampled mid-way through the high phase
   task automatic xfer_bit(input logic b, output logic r);
      o_sda_oe = ~b;
      qtr();
      o_scl = 1'b1;
      qtr();
      r = i_sda;
      qtr();
      o_scl = 1'b0;
      qtr();
   endtask : xfer_bit

   // Eight bits out MSB first, then the slave's answer in the ninth clock
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
      xfer_bit(1'b1, r);
      ack = ~r;
   endtask : send_byte

   // Eight bits in, then ack or a closing not-acknowledge
   task automatic recv_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, r);
         d[i] = r;
      end
      xfer_bit(last, r);
   endtask : recv_byte
endmodule : eesl_bus_master

// *** dv/tb_i2c_serial_eeprom_slave.sv ***
// Self-checking bench for the two-wire serial EEPROM slave
`timescale 1ns/1ps
module tb_i2c_serial_eeprom_slave;
   import eesl_pkg::*;
   localparam int unsigned WR_CYC = 600;     // Long enough that one poll lands inside busy
   localparam logic [2:0]  STRAP  = 3'h5;
   localparam int unsigned LIMIT  = 60000;   // About three times the expected run
   logic       clk;
   logic       rst_n;
   logic       scl;
   logic       m_oe;
   logic       d_oe;
   logic       d_out;
   logic       sda;
   logic       wp;
   logic       busy;
   logic [2:0] cs;
   int         err_count;
   int         check_count;
   int         cycles;

   // Pull-up wins unless a party pulls the wire low
   assign sda = ~(m_oe | d_oe);

   always #5 clk = ~clk;

   eesl_top #(.P_WRITE_CYCLES(WR_CYC)) dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_scl_clk(scl), .i_scl(scl), .i_sda_in(sda),
      .o_sda_out(d_out), .o_sda_oe(d_oe), .i_chip_select_bit0(cs[0]), .i_chip_select_bit1(cs[1]),
      .i_chip_select_bit2(cs[2]), .i_write_protect(wp), .o_busy(busy));

   eesl_bus_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

   // ============================================================
   // Reporting
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task automatic chk_bit(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %0b seen %0b", what, exp, got);
      end
   endtask : chk_bit

   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_byte

   // A hang in the slave's handshake ends here rather than running forever
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_count++;
         summarize();
      end
   end

   // ============================================================
   // Transfer helpers
   function automatic logic [7:0] dev(input logic rd);
      return {DEV_TYPE, STRAP, rd};
   endfunction : dev

   task automatic set_addr(input logic [15:0] a);
      logic ack;
      m.start();
      m.send_byte(dev(1'b0), ack);
      chk_bit("ack address", 1'b1, ack);
      m.send_byte(a[15:8], ack);
      chk_bit("ack high", 1'b1, ack);
      m.send_byte(a[7:0], ack);
      chk_bit("ack low", 1'b1, ack);
   endtask : set_addr

   task automatic rd_cur(input logic [7:0] exp);
      logic       ack;
      logic [7:0] d;
      m.start();
      m.send_byte(dev(1'b1), ack);
      chk_bit("ack read", 1'b1, ack);
      m.recv_byte(1'b1, d);
      m.stop();
      chk_byte("read byte", exp, d);
   endtask : rd_cur

   task automatic rd_seq(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
      logic       ack;
      logic [7:0] d;
      set_addr(a);
      m.start();
      m.send_byte(dev(1'b1), ack);
      chk_bit("ack read", 1'b1, ack);
      m.recv_byte(1'b0, d);
      chk_byte("seq first", e0, d);
      m.recv_byte(1'b1, d);
      m.stop();
      chk_byte("seq second", e1, d);
   endtask : rd_seq

   // Selective read of one byte: dummy write then repeated start
   task automatic rd1(input logic [15:0] a, input logic [7:0] exp);
      set_addr(a);
      rd_cur(exp);
   endtask : rd1

   task automatic wr(input logic [15:0] a, input int n, input logic [7:0] base, input logic exp_ack);
      logic ack;
      set_addr(a);
      for (int i = 0; i < n; i++) begin
         m.send_byte(base + 8'(i), ack);
         chk_bit("ack data", exp_ack, ack);
      end
      m.stop();
   endtask : wr

   task automatic wait_idle();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      chk_bit("busy ends", 1'b0, busy);
   endtask : wait_idle

   // ============================================================
   // Scenarios
   task automatic t_addr();
      logic ack;
      m.start();
      m.send_byte({4'hB, STRAP, 1'b0}, ack);
      chk_bit("wrong type", 1'b0, ack);
      m.start();
      m.send_byte({DEV_TYPE, STRAP ^ 3'h1, 1'b0}, ack);
      chk_bit("wrong strap0", 1'b0, ack);
      m.start();
      m.send_byte({DEV_TYPE, STRAP ^ 3'h4, 1'b1}, ack);
      chk_bit("wrong strap2", 1'b0, ack);
      m.stop();
      // First bit is a one, so no false start is made from the idle clock
      m.send_byte(dev(1'b0), ack);
      chk_bit("no start", 1'b0, ack);
      m.stop();
      rd1(16'h1234, ERASED_BYTE);
      $display("test address done");
   endtask : t_addr

   task automatic t_page();
      logic ack;
      wr(16'h01FE, 3, 8'hA1, 1'b1);
      @(negedge clk);
      chk_bit("busy after stop", 1'b1, busy);
      m.start();
      m.send_byte(dev(1'b0), ack);
      chk_bit("poll while busy", 1'b0, ack);
      m.stop();
      wait_idle();
      rd_cur(ERASED_BYTE);
      rd_seq(16'h01FF, 8'hA2, ERASED_BYTE);
      rd1(16'h0180, 8'hA3);
      rd1(16'h01FE, 8'hA1);
      $display("test page done");
   endtask : t_page

   task automatic t_protect();
      wp = 1'b1;
      wr(16'h0010, 1, 8'h55, 1'b0);
      @(negedge clk);
      chk_bit("no busy", 1'b0, busy);
      wp = 1'b0;
      rd1(16'h0010, ERASED_BYTE);
      $display("test protect done");
   endtask : t_protect

   task automatic t_wrap();
      int k;
      wr(16'h0000, 1, 8'h5A, 1'b1);
      // Busy started a few cycles into the stop's last quarter, so a little under the full length remains
      k = 0;
      while (busy === 1'b1 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      chk_bit("busy length", 1'b1, (k > WR_CYC - 12) && (k <= WR_CYC));
      wait_idle();
      rd_seq(16'hFFFF, ERASED_BYTE, 8'h5A);
      rd_cur(ERASED_BYTE);
      $display("test wrap done");
   endtask : t_wrap

   // Reset in mid-programming must drop busy and release the wire
   task automatic t_reset();
      wr(16'h0040, 1, 8'h77, 1'b1);
      repeat (20) @(negedge clk);
      chk_bit("busy before reset", 1'b1, busy);
      rst_n = 1'b0;
      @(negedge clk);
      chk_bit("busy in reset", 1'b0, busy);
      chk_bit("oe in reset", 1'b0, d_oe);
      chk_bit("sda data level", 1'b0, d_out);
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      chk_bit("busy after reset", 1'b0, busy);
      // Reset clears the counter to 0000h but not the array, which still holds the wrap test's byte
      rd_cur(8'h5A);
      $display("test reset done");
   endtask : t_reset

   // ============================================================
   // Main sequence
   initial begin
      clk         = 1'b0;
      rst_n       = 1'b0;
      wp          = 1'b0;
      cs          = STRAP;
      err_count   = 0;
      check_count = 0;
      cycles      = 0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      t_addr();
      t_page();
      t_protect();
      t_wrap();
      t_reset();
      summarize();
   end
endmodule : tb_i2c_serial_eeprom_slave
